// file: hw/clb_defines.svh
// constants for the counted loop branch unit
`ifndef CLB_DEFINES_SVH
`define CLB_DEFINES_SVH

// opcodes of the three counted loop forms
`define CLB_OP_LOOP       8'he2
`define CLB_OP_LOOP_EQ    8'he1
`define CLB_OP_LOOP_NE    8'he0

// cycle figures per outcome, first of each pair is the taken case
`define CLB_CYC_PLAIN_TK  4'h2
`define CLB_CYC_PLAIN_NT  4'h6
`define CLB_CYC_COND_TK   4'h9
`define CLB_CYC_COND_NT   4'h6
`define CLB_CYC_BAD       4'h1

// general protection error code and fetch size after a branch
`define CLB_GP_CODE       16'h0000
`define CLB_FETCH_BYTES   16
`define CLB_FETCH_LEN_W   5

// legal displacement span around the loop instruction
`define CLB_DISP_BACK     128
`define CLB_DISP_FWD      127

`endif

// file: hw/clb_pkg.sv
// types shared by the counted loop branch unit
`include "clb_defines.svh"

package clb_pkg;

  // decoded loop form
  typedef enum logic [1:0] {
    CLB_K_PLAIN = 2'h0,
    CLB_K_EQ    = 2'h1,
    CLB_K_NE    = 2'h2,
    CLB_K_BAD   = 2'h3
  } clb_kind_t;

  // sequencer states, gray along idle, exec, fetch
  typedef enum logic [1:0] {
    CLB_S_IDLE  = 2'h0,
    CLB_S_EXEC  = 2'h1,
    CLB_S_FETCH = 2'h3
  } clb_state_t;

  // one issued loop instruction with its operands
  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  short_displacement;
    logic        addr16;
    logic        op16;
    logic        prot_mode;
    logic        zero_flag;
    logic [31:0] count;
    logic [31:0] instr_pointer;
    logic [31:0] cs_limit;
  } clb_req_t;

  // outcome of one loop instruction
  typedef struct packed {
    logic        bad_op;
    logic        taken;
    logic        gp_fault;
    logic [15:0] err_code;
    logic [31:0] count_new;
    logic [31:0] instr_pointer;
  } clb_res_t;

  // code fetch request after a taken branch
  typedef struct packed {
    logic [31:0]                 addr;
    logic [`CLB_FETCH_LEN_W-1:0] len;
  } clb_fetch_t;

endpackage

// file: hw/clb_cond_eval.sv
// decode, count update and branch condition of one loop instruction
`include "clb_defines.svh"

module clb_cond_eval (
  input  clb_pkg::clb_req_t  i_req,
  output clb_pkg::clb_kind_t o_kind,
  output clb_pkg::clb_res_t  o_res,
  output logic [3:0]         o_cycles
);
  import clb_pkg::*;

  logic [31:0] selected_counter;
  logic [31:0] disp_wide;
  logic [31:0] target;
  logic        cnt_nonzero;
  logic        take_branch;
  logic        gp;

  always_comb begin
    case (i_req.opcode)
      `CLB_OP_LOOP:    o_kind = CLB_K_PLAIN;
      `CLB_OP_LOOP_EQ: o_kind = CLB_K_EQ;
      `CLB_OP_LOOP_NE: o_kind = CLB_K_NE;
      default:         o_kind = CLB_K_BAD;
    endcase
  end

  // counter, condition, target and fault check
  always_comb begin
    disp_wide = {{24{i_req.short_displacement[7]}},
                 i_req.short_displacement};
    if (i_req.addr16) begin
      selected_counter = {i_req.count[31:16],
                          i_req.count[15:0] - 16'h0001};
      cnt_nonzero      = |selected_counter[15:0];
    end else begin
      selected_counter = i_req.count - 32'h0000_0001;
      cnt_nonzero      = |selected_counter;
    end
    case (o_kind)
      CLB_K_PLAIN: take_branch = cnt_nonzero;
      CLB_K_EQ:    take_branch = cnt_nonzero & i_req.zero_flag;
      CLB_K_NE:    take_branch = cnt_nonzero & ~i_req.zero_flag;
      default:     take_branch = 1'b0;
    endcase
    // narrow pointer keeps its upper half
    if (i_req.op16) begin
      target = {i_req.instr_pointer[31:16],
                i_req.instr_pointer[15:0] + disp_wide[15:0]};
    end else begin
      target = i_req.instr_pointer + disp_wide;
    end
    // limit check only in protected mode
    gp = take_branch & i_req.prot_mode & (target > i_req.cs_limit);
    o_res.bad_op   = (o_kind == CLB_K_BAD);
    o_res.taken    = take_branch & ~gp;
    o_res.gp_fault = gp;
    o_res.err_code = `CLB_GP_CODE;
    // a fault or an unknown opcode leaves the count as it was
    o_res.count_new = (gp | o_res.bad_op) ? i_req.count
                                          : selected_counter;
    // not taken stays on the sequential pointer
    o_res.instr_pointer = o_res.taken ? target : i_req.instr_pointer;
    // cycle figure per form and outcome
    case (o_kind)
      CLB_K_PLAIN: o_cycles = take_branch ? `CLB_CYC_PLAIN_TK
                                          : `CLB_CYC_PLAIN_NT;
      CLB_K_EQ,
      CLB_K_NE:    o_cycles = take_branch ? `CLB_CYC_COND_TK
                                          : `CLB_CYC_COND_NT;
      default:     o_cycles = `CLB_CYC_BAD;
    endcase
  end

endmodule

// file: hw/clb_loop_unit.sv
// counted loop branch execution unit with timing and fetch request
`include "clb_defines.svh"

module clb_loop_unit #(
  parameter int FETCH_BYTES = `CLB_FETCH_BYTES
) (
  input  wire logic          I_SYS_CLK,
  input  wire logic          I_RESETN,
  input  wire logic          I_ISSUE,
  input  clb_pkg::clb_req_t  I_REQ,
  input  wire logic          I_FETCH_ACK,
  output logic               O_BUSY,
  output logic               O_DONE,
  output clb_pkg::clb_res_t  O_RESULT,
  output logic [3:0]         O_CYCLES,
  output logic               O_FETCH_REQ,
  output clb_pkg::clb_fetch_t O_FETCH
);
  import clb_pkg::*;

  // the fetch length field and alignment mask need a power of two
  if (FETCH_BYTES < 2 || FETCH_BYTES >= (1 << `CLB_FETCH_LEN_W) ||
      (FETCH_BYTES & (FETCH_BYTES - 1)) != 0) begin : g_bad_fetch
    $error("fetch size must be a power of two from 2 to 16");
  end

  localparam logic [31:0] FETCH_MASK = ~(32'(FETCH_BYTES) - 32'h1);
  localparam logic [`CLB_FETCH_LEN_W-1:0] FETCH_LEN =
    `CLB_FETCH_LEN_W'(FETCH_BYTES);

  logic        rst_meta_q;
  logic        rst_sync_q;
  logic        rst_n;

  clb_state_t  state_q;
  clb_state_t  state_d;
  logic [3:0]  wait_q;
  logic [3:0]  wait_d;
  clb_res_t    hold_q;
  clb_res_t    hold_d;
  logic        busy_q;
  logic        busy_d;
  logic        done_q;
  logic        done_d;
  clb_res_t    res_q;
  clb_res_t    res_d;
  logic [3:0]  cycles_q;
  logic [3:0]  cycles_d;
  logic        fetch_req_q;
  logic        fetch_req_d;
  clb_fetch_t  fetch_q;
  clb_fetch_t  fetch_d;

  clb_kind_t   eval_kind;
  clb_res_t    eval_res;
  logic [3:0]  eval_cycles;
  logic        accept;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // operands are evaluated at issue so the result is ready early
  clb_cond_eval u_eval (
    .i_req    (I_REQ),
    .o_kind   (eval_kind),
    .o_res    (eval_res),
    .o_cycles (eval_cycles)
  );

  assign accept = (state_q == CLB_S_IDLE) && I_ISSUE;

  // sequencer next state and output values
  always_comb begin
    state_d     = state_q;
    wait_d      = wait_q;
    hold_d      = hold_q;
    done_d      = 1'b0;
    res_d       = res_q;
    cycles_d    = cycles_q;
    fetch_req_d = fetch_req_q;
    fetch_d     = fetch_q;
    case (state_q)
      CLB_S_IDLE: begin
        if (I_ISSUE) begin
          hold_d   = eval_res;
          cycles_d = eval_cycles;
          // hold busy for the documented figure
          wait_d   = eval_cycles - 4'h1;
          state_d  = CLB_S_EXEC;
        end
      end
      CLB_S_EXEC: begin
        if (wait_q == 4'h0) begin
          done_d = 1'b1;
          res_d  = hold_q;
          if (hold_q.taken) begin
            // line fetch at the new target
            fetch_req_d  = 1'b1;
            fetch_d.addr = hold_q.instr_pointer & FETCH_MASK;
            fetch_d.len  = FETCH_LEN;
            state_d      = CLB_S_FETCH;
          end else begin
            state_d = CLB_S_IDLE;
          end
        end else begin
          wait_d = wait_q - 4'h1;
        end
      end
      CLB_S_FETCH: begin
        // request stands until the fetch side takes it
        if (I_FETCH_ACK) begin
          fetch_req_d = 1'b0;
          state_d     = CLB_S_IDLE;
        end
      end
      default: begin
        state_d     = CLB_S_IDLE;
        fetch_req_d = 1'b0;
      end
    endcase
    busy_d = (state_d != CLB_S_IDLE);
  end

  // sequencer registers
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= CLB_S_IDLE;
      wait_q      <= 4'h0;
      hold_q      <= '0;
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      res_q       <= '0;
      cycles_q    <= 4'h0;
      fetch_req_q <= 1'b0;
      fetch_q     <= '0;
    end else begin
      state_q     <= state_d;
      wait_q      <= wait_d;
      hold_q      <= hold_d;
      busy_q      <= busy_d;
      done_q      <= done_d;
      res_q       <= res_d;
      cycles_q    <= cycles_d;
      fetch_req_q <= fetch_req_d;
      fetch_q     <= fetch_d;
    end
  end

  // all outputs straight from flops
  assign O_BUSY      = busy_q;
  assign O_DONE      = done_q;
  assign O_RESULT    = res_q;
  assign O_CYCLES    = cycles_q;
  assign O_FETCH_REQ = fetch_req_q;
  assign O_FETCH     = fetch_q;

  // checking helpers: captured request and cycles since issue
  clb_req_t    acc_q;
  logic [3:0]  lat_q;
  logic [15:0] nar_dec;
  logic [3:0]  exp_cyc;
  logic        acc_cond;

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      lat_q <= 4'h0;
    end else begin
      if (accept) begin
        acc_q <= I_REQ;
      end
      // zero at the accepting edge, so it reads n when done stands
      if (accept) begin
        lat_q <= 4'h0;
      end else if (lat_q != 4'hf) begin
        lat_q <= lat_q + 4'h1;
      end
    end
  end

  // expected condition and figure from the captured operands
  always_comb begin
    nar_dec  = acc_q.count[15:0] - 16'h0001;
    acc_cond = acc_q.addr16 ? (nar_dec != 16'h0)
                            : (acc_q.count != 32'h1);
    case (acc_q.opcode)
      `CLB_OP_LOOP: begin
        exp_cyc = acc_cond ? `CLB_CYC_PLAIN_TK : `CLB_CYC_PLAIN_NT;
      end
      `CLB_OP_LOOP_EQ: begin
        acc_cond = acc_cond & acc_q.zero_flag;
        exp_cyc  = acc_cond ? `CLB_CYC_COND_TK : `CLB_CYC_COND_NT;
      end
      `CLB_OP_LOOP_NE: begin
        acc_cond = acc_cond & ~acc_q.zero_flag;
        exp_cyc  = acc_cond ? `CLB_CYC_COND_TK : `CLB_CYC_COND_NT;
      end
      default: begin
        acc_cond = 1'b0;
        exp_cyc  = `CLB_CYC_BAD;
      end
    endcase
  end

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!rst_n);

  decode_bad_a: assert property (
    O_DONE |-> O_RESULT.bad_op == !(acc_q.opcode inside
      {`CLB_OP_LOOP, `CLB_OP_LOOP_EQ, `CLB_OP_LOOP_NE}))
    else $error("unknown opcode flag wrong");

  narrow_count_a: assert property (
    O_DONE && acc_q.addr16 && !O_RESULT.gp_fault && !O_RESULT.bad_op
    |-> O_RESULT.count_new == {acc_q.count[31:16], nar_dec})
    else $error("narrow counter update wrong");

  wide_count_a: assert property (
    O_DONE && !acc_q.addr16 && !O_RESULT.gp_fault && !O_RESULT.bad_op
    |-> O_RESULT.count_new == acc_q.count - 32'h1)
    else $error("wide counter update wrong");

  plain_cond_a: assert property (
    O_DONE && acc_q.opcode == `CLB_OP_LOOP
    |-> (O_RESULT.taken || O_RESULT.gp_fault) == acc_cond)
    else $error("plain loop condition wrong");

  equal_cond_a: assert property (
    O_DONE && acc_q.opcode == `CLB_OP_LOOP_EQ
    |-> (O_RESULT.taken || O_RESULT.gp_fault) == acc_cond)
    else $error("equal form condition wrong");

  unequal_cond_a: assert property (
    O_DONE && acc_q.opcode == `CLB_OP_LOOP_NE
    |-> (O_RESULT.taken || O_RESULT.gp_fault) == acc_cond)
    else $error("unequal form condition wrong");

  target_calc_a: assert property (
    O_DONE && O_RESULT.taken && !acc_q.op16
    |-> O_RESULT.instr_pointer == acc_q.instr_pointer +
        {{24{acc_q.short_displacement[7]}}, acc_q.short_displacement})
    else $error("wide branch target wrong");

  narrow_target_a: assert property (
    O_DONE && O_RESULT.taken && acc_q.op16
    |-> O_RESULT.instr_pointer[31:16] == acc_q.instr_pointer[31:16] &&
        O_RESULT.instr_pointer[15:0] == acc_q.instr_pointer[15:0] +
        {{8{acc_q.short_displacement[7]}}, acc_q.short_displacement})
    else $error("narrow branch target wrong");

  cycle_figure_a: assert property (
    O_DONE |-> lat_q == exp_cyc && O_CYCLES == exp_cyc)
    else $error("cycle figure wrong");

  // done is set n edges after accept and sampled one edge later
  done_bound_a: assert property (
    accept |-> ##[2:10] O_DONE)
    else $error("no completion within ten cycles");

  limit_fault_a: assert property (
    O_DONE && O_RESULT.gp_fault
    |-> acc_q.prot_mode && acc_cond && !O_RESULT.taken &&
        O_RESULT.err_code == `CLB_GP_CODE &&
        O_RESULT.count_new == acc_q.count)
    else $error("limit fault reported wrongly");

  fetch_issue_a: assert property (
    O_DONE && O_RESULT.taken
    |-> O_FETCH_REQ && O_FETCH.len == FETCH_LEN &&
        O_FETCH.addr == (O_RESULT.instr_pointer & FETCH_MASK))
    else $error("taken branch without line fetch");

  fetch_hold_a: assert property (
    O_FETCH_REQ && !I_FETCH_ACK |=> O_FETCH_REQ && $stable(O_FETCH))
    else $error("fetch request dropped early");

  seq_continue_a: assert property (
    O_DONE && !O_RESULT.taken
    |-> O_RESULT.instr_pointer == acc_q.instr_pointer && !O_FETCH_REQ)
    else $error("not taken path moved pointer");

  plain_taken_c: cover property (
    O_DONE && O_RESULT.taken && acc_q.opcode == `CLB_OP_LOOP);
  equal_exit_c: cover property (
    O_DONE && !O_RESULT.taken && acc_q.opcode == `CLB_OP_LOOP_EQ);
  limit_fault_c: cover property (O_DONE && O_RESULT.gp_fault);
  fetch_stall_c: cover property ((O_FETCH_REQ && !I_FETCH_ACK) [*3]);

endmodule

// file: sim/clb_loop_unit_tb.sv
// self-checking bench for the counted loop branch unit
module clb_loop_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import clb_pkg::*;

  logic       sys_clk;
  logic       resetn;
  logic       issue;
  logic       fetch_ack;
  clb_req_t   req;
  logic       busy;
  logic       done;
  clb_res_t   res;
  logic [3:0] cyc;
  logic       fetch_req;
  clb_fetch_t fet;
  int         fails;
  int         compares;

  clb_loop_unit #(
    .FETCH_BYTES (16)
  ) i_clb_loop_unit (
    .I_SYS_CLK   (sys_clk),
    .I_RESETN    (resetn),
    .I_ISSUE     (issue),
    .I_REQ       (req),
    .I_FETCH_ACK (fetch_ack),
    .O_BUSY      (busy),
    .O_DONE      (done),
    .O_RESULT    (res),
    .O_CYCLES    (cyc),
    .O_FETCH_REQ (fetch_req),
    .O_FETCH     (fet)
  );

  // 10 MHz core clock
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  // four-state compare, an unknown matches only an unknown
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // one instruction; mode is {addr16, op16, prot, zf}, flags {tk, gp, bad}
  task automatic exec(input logic [7:0] op, input logic [7:0] disp,
                      input logic [3:0] mode, input logic [31:0] cnt,
                      input logic [31:0] ip, input logic [31:0] lim,
                      input logic [2:0] flags, input logic [31:0] ecnt,
                      input logic [31:0] instr_pointer_wide, input logic [3:0] ecyc,
                      input int stall);
    int n;
    @(negedge sys_clk);
    req = '{op, disp, mode[3], mode[2], mode[1], mode[0], cnt, ip, lim};
    issue = 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    issue = 1'b0;
    // operands must have been captured at the accept edge
    req.instr_pointer = ~ip;
    // n counts edges after the accepting one
    n = 0;
    while (done !== 1'b1 && n < 16) begin
      @(negedge sys_clk);
      n++;
    end
    chk("latency", {28'h0, ecyc}, n);
    chk("cycles", {28'h0, ecyc}, {28'h0, cyc});
    chk("taken", {31'h0, flags[2]}, {31'h0, res.taken});
    chk("fault", {31'h0, flags[1]}, {31'h0, res.gp_fault});
    chk("bad op", {31'h0, flags[0]}, {31'h0, res.bad_op});
    chk("error code", 32'h0, {16'h0, res.err_code});
    chk("count", ecnt, res.count_new);
    chk("pointer", instr_pointer_wide, res.instr_pointer);
    chk("fetch req", {31'h0, flags[2]}, {31'h0, fetch_req});
    if (flags[2]) begin
      chk("fetch addr", {instr_pointer_wide[31:4], 4'h0}, fet.addr);
      chk("fetch len", 32'h10, {27'h0, fet.len});
      // a second issue while the fetch waits must be dropped
      issue = (stall > 0);
      repeat (stall) begin
        @(negedge sys_clk);
        chk("held fetch", 32'h1, {31'h0, fetch_req});
        chk("refused issue", 32'h0, {31'h0, done});
      end
      // only lowered if raised, never twice in one step
      if (stall > 0) begin
        issue = 1'b0;
      end
      fetch_ack = 1'b1;
      @(negedge sys_clk);
      fetch_ack = 1'b0;
      chk("fetch retired", 32'h0, {31'h0, fetch_req});
      chk("busy after ack", 32'h0, {31'h0, busy});
    end else begin
      chk("busy at done", 32'h0, {31'h0, busy});
      @(negedge sys_clk);
      chk("done pulse", 32'h0, {31'h0, done});
    end
  endtask

  // plain form ignores the flag, count zero wraps and still branches
  task automatic t_plain();
    exec(8'he2, 8'h10, 4'h0, 32'h5, 32'h1000, 32'hffffffff, 3'b100,
         32'h4, 32'h1010, 4'h2, 3);
    exec(8'he2, 8'h10, 4'h1, 32'h1, 32'h1000, 32'hffffffff, 3'b000,
         32'h0, 32'h1000, 4'h6, 0);
    exec(8'he2, 8'h80, 4'h0, 32'h0, 32'h1000, 32'hffffffff, 3'b100,
         32'hffffffff, 32'h0f80, 4'h2, 0);
    $display("plain loop test done");
  endtask

  // both conditional forms against flag and count
  // targets at span ends
  task automatic t_cond();
    exec(8'he1, 8'h7f, 4'h1, 32'h3, 32'h1000, 32'hffffffff, 3'b100,
         32'h2, 32'h107f, 4'h9, 1);
    exec(8'he1, 8'h7f, 4'h0, 32'h3, 32'h1000, 32'hffffffff, 3'b000,
         32'h2, 32'h1000, 4'h6, 0);
    exec(8'he1, 8'h7f, 4'h1, 32'h1, 32'h1000, 32'hffffffff, 3'b000,
         32'h0, 32'h1000, 4'h6, 0);
    exec(8'he0, 8'h80, 4'h0, 32'h3, 32'h1000, 32'hffffffff, 3'b100,
         32'h2, 32'h0f80, 4'h9, 2);
    exec(8'he0, 8'h80, 4'h1, 32'h3, 32'h1000, 32'hffffffff, 3'b000,
         32'h2, 32'h1000, 4'h6, 0);
    exec(8'he0, 8'h80, 4'h0, 32'h1, 32'h1000, 32'hffffffff, 3'b000,
         32'h0, 32'h1000, 4'h6, 0);
    $display("conditional loop test done");
  endtask

  // narrow counter and narrow pointer keep their upper halves
  task automatic t_narrow();
    exec(8'he2, 8'h10, 4'h8, 32'h12340001, 32'h1000, 32'hffffffff,
         3'b000, 32'h12340000, 32'h1000, 4'h6, 0);
    exec(8'he2, 8'h10, 4'h8, 32'habcd0000, 32'h1000, 32'hffffffff,
         3'b100, 32'habcdffff, 32'h1010, 4'h2, 0);
    exec(8'he2, 8'h20, 4'h4, 32'h2, 32'h0001fff0, 32'hffffffff,
         3'b100, 32'h1, 32'h00010010, 4'h2, 0);
    exec(8'he2, 8'hf0, 4'h4, 32'h2, 32'h00010008, 32'hffffffff,
         3'b100, 32'h1, 32'h0001fff8, 4'h2, 0);
    $display("narrow size test done");
  endtask

  // limit check only in protected mode and only when branching
  task automatic t_fault();
    exec(8'he1, 8'h10, 4'h3, 32'h3, 32'h1000, 32'h100f, 3'b010,
         32'h3, 32'h1000, 4'h9, 0);
    exec(8'he2, 8'h10, 4'h2, 32'h5, 32'h1000, 32'h100f, 3'b010,
         32'h5, 32'h1000, 4'h2, 0);
    exec(8'he2, 8'h10, 4'h2, 32'h5, 32'h1000, 32'h1010, 3'b100,
         32'h4, 32'h1010, 4'h2, 0);
    exec(8'he2, 8'h10, 4'h0, 32'h5, 32'h1000, 32'h100f, 3'b100,
         32'h4, 32'h1010, 4'h2, 0);
    exec(8'he1, 8'h10, 4'h2, 32'h3, 32'h1000, 32'h100f, 3'b000,
         32'h2, 32'h1000, 4'h6, 0);
    $display("limit fault test done");
  endtask

  // neighbours of the three opcodes are rejected untouched
  task automatic t_bad();
    exec(8'he3, 8'h10, 4'h1, 32'h5, 32'h1000, 32'hffffffff, 3'b001,
         32'h5, 32'h1000, 4'h1, 0);
    exec(8'hdf, 8'h10, 4'h0, 32'h5, 32'h1000, 32'hffffffff, 3'b001,
         32'h5, 32'h1000, 4'h1, 0);
    $display("bad opcode test done");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence, inputs move on the falling edge
  initial begin
    fails = 0;
    compares = 0;
    resetn = 1'b0;
    issue = 1'b0;
    fetch_ack = 1'b0;
    req = '0;
    repeat (6) @(negedge sys_clk);
    resetn = 1'b1;
    // release passes two flops before the unit listens
    repeat (3) @(negedge sys_clk);
    chk("reset busy", 32'h0, {31'h0, busy});
    chk("reset fetch", 32'h0, {31'h0, fetch_req});
    t_plain();
    t_cond();
    t_narrow();
    t_fault();
    t_bad();
    wrap_up();
  end

  // whole run is under two hundred cycles, so 1 ms means a hang
  initial begin
    #1000000;
    fails++;
    wrap_up();
  end
endmodule
